// file: hdl/eeu_top.sv
// Purpose: Data EEPROM byte write with two-key unlock, reached over AXI4-Lite.
// Assumes: EXT_RST_REQ is an asynchronous system reset request (external or watchdog).
// Notes: RST_B is the power-on reset and clears the abort flag; EXT_RST_REQ does not.
`default_nettype none

module eeu_top #(
    parameter int unsigned MEM_AW = 8,
    parameter int unsigned CNT_W = 16,
    parameter int unsigned PROG_CYCLES = eeu_pkg::PROG_CYCLES
) (
    input  wire logic                       CLK_SYS,
    input  wire logic                       RST_B,
    input  wire logic                       EXT_RST_REQ,
    input  wire logic                       S_AXI_AWVALID,
    output logic                            S_AXI_AWREADY,
    input  wire logic [eeu_pkg::AXI_AW-1:0] S_AXI_AWADDR,
    input  wire logic                       S_AXI_WVALID,
    output logic                            S_AXI_WREADY,
    input  wire logic [31:0]                S_AXI_WDATA,
    input  wire logic [3:0]                 S_AXI_WSTRB,
    output logic                            S_AXI_BVALID,
    input  wire logic                       S_AXI_BREADY,
    output logic [1:0]                      S_AXI_BRESP,
    input  wire logic                       S_AXI_ARVALID,
    output logic                            S_AXI_ARREADY,
    input  wire logic [eeu_pkg::AXI_AW-1:0] S_AXI_ARADDR,
    output logic                            S_AXI_RVALID,
    input  wire logic                       S_AXI_RREADY,
    output logic [31:0]                     S_AXI_RDATA,
    output logic [1:0]                      S_AXI_RRESP,
    output logic                            IRQ
);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PROG_CYCLES - 1);

    function automatic logic is_mapped(input logic [eeu_pkg::IDX_W-1:0] idx);
        is_mapped = (idx == eeu_pkg::IDX_DATA) || (idx == eeu_pkg::IDX_ADDR) ||
                    (idx == eeu_pkg::IDX_CTRL) || (idx == eeu_pkg::IDX_UNLK) ||
                    (idx == eeu_pkg::IDX_STAT) || (idx == eeu_pkg::IDX_MASK);
    endfunction

    eeu_mem_if #(.AW(MEM_AW), .DW(8)) mem_bus ();

    eeu_mem #(.AW(MEM_AW), .DW(8)) u_mem (
        .clk   (CLK_SYS),
        .rst_b (RST_B),
        .port  (mem_bus)
    );

    // Reset request synchroniser and agreement filter.
    logic [2:0] ext_s_q;
    logic [2:0] ext_s_d;
    logic       ext_f_q;
    logic       ext_f_d;

    always_comb
    begin
        ext_s_d = {ext_s_q[1:0], EXT_RST_REQ};
        ext_f_d = (ext_s_q[1] == ext_s_q[2]) ? ext_s_q[2] : ext_f_q;
    end

    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
        begin
            ext_s_q <= 3'h0;
            ext_f_q <= 1'b0;
        end
        else
        begin
            ext_s_q <= ext_s_d;
            ext_f_q <= ext_f_d;
        end
    end

    // Bus slave: address and data are taken in either order, then committed together.
    logic                      aw_have_q;
    logic                      aw_have_d;
    logic [eeu_pkg::IDX_W-1:0] aw_idx_q;
    logic [eeu_pkg::IDX_W-1:0] aw_idx_d;
    logic                      w_have_q;
    logic                      w_have_d;
    logic [7:0]                w_data_q;
    logic [7:0]                w_data_d;
    logic                      w_stb_q;
    logic                      w_stb_d;
    logic                      bvalid_q;
    logic                      bvalid_d;
    logic [1:0]                bresp_q;
    logic [1:0]                bresp_d;
    logic                      rvalid_q;
    logic                      rvalid_d;
    logic [31:0]               rdata_q;
    logic [31:0]               rdata_d;
    logic [1:0]                rresp_q;
    logic [1:0]                rresp_d;
    logic                      wr_go;
    logic                      ar_fire;
    logic [eeu_pkg::IDX_W-1:0] ar_idx;
    logic [7:0]                rd_mux;

    // Control state.
    logic                      done_q;
    logic                      done_d;
    logic                      abort_q;
    logic                      abort_d;
    logic                      permit_q;
    logic                      permit_d;
    logic                      go_q;
    logic                      go_d;
    logic                      rd_q;
    logic                      rd_d;
    logic [7:0]                data_q;
    logic [7:0]                data_d;
    logic [7:0]                addr_q;
    logic [7:0]                addr_d;
    logic [7:0]                paddr_q;
    logic [7:0]                paddr_d;
    logic [7:0]                pdata_q;
    logic [7:0]                pdata_d;
    logic [CNT_W-1:0]          cnt_q;
    logic [CNT_W-1:0]          cnt_d;
    logic [1:0]                stat_q;
    logic [1:0]                stat_d;
    logic [1:0]                mask_q;
    logic [1:0]                mask_d;
    eeu_pkg::eeu_ulk_t         ulk_q;
    eeu_pkg::eeu_ulk_t         ulk_d;
    logic                      wr_ctrl;
    logic                      go_req;
    logic                      rd_req;
    logic                      prog_end;
    logic                      cut_short;

    assign S_AXI_AWREADY = !aw_have_q && !bvalid_q;
    assign S_AXI_WREADY  = !w_have_q && !bvalid_q;
    assign S_AXI_ARREADY = !rvalid_q;
    assign S_AXI_BVALID  = bvalid_q;
    assign S_AXI_BRESP   = bresp_q;
    assign S_AXI_RVALID  = rvalid_q;
    assign S_AXI_RDATA   = rdata_q;
    assign S_AXI_RRESP   = rresp_q;
    assign IRQ           = |(stat_q & mask_q);

    assign wr_go   = aw_have_q && w_have_q;
    assign ar_fire = S_AXI_ARVALID && !rvalid_q;
    assign ar_idx  = S_AXI_ARADDR[eeu_pkg::AXI_AW-1:2];

    always_comb
    begin
        case (ar_idx)
            eeu_pkg::IDX_DATA: rd_mux = data_q;
            eeu_pkg::IDX_ADDR: rd_mux = addr_q;
            eeu_pkg::IDX_CTRL: rd_mux = {3'h0, done_q, abort_q, permit_q, go_q, rd_q};
            eeu_pkg::IDX_STAT: rd_mux = {6'h00, stat_q};
            eeu_pkg::IDX_MASK: rd_mux = {6'h00, mask_q};
            default:           rd_mux = 8'h00;
        endcase
    end

    always_comb
    begin
        aw_have_d = aw_have_q;
        aw_idx_d  = aw_idx_q;
        w_have_d  = w_have_q;
        w_data_d  = w_data_q;
        w_stb_d   = w_stb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        if (S_AXI_AWVALID && S_AXI_AWREADY)
        begin
            aw_have_d = 1'b1;
            aw_idx_d  = S_AXI_AWADDR[eeu_pkg::AXI_AW-1:2];
        end
        if (S_AXI_WVALID && S_AXI_WREADY)
        begin
            w_have_d = 1'b1;
            w_data_d = S_AXI_WDATA[7:0];
            w_stb_d  = S_AXI_WSTRB[0];
        end
        if (wr_go)
        begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = is_mapped(aw_idx_q) ? eeu_pkg::RESP_OKAY : eeu_pkg::RESP_SLVERR;
        end
        else if (bvalid_q && S_AXI_BREADY)
        begin
            bvalid_d = 1'b0;
        end
        if (ar_fire)
        begin
            rvalid_d = 1'b1;
            rdata_d  = {24'h00_0000, rd_mux};
            rresp_d  = is_mapped(ar_idx) ? eeu_pkg::RESP_OKAY : eeu_pkg::RESP_SLVERR;
        end
        else if (rvalid_q && S_AXI_RREADY)
        begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
        begin
            aw_have_q <= 1'b0;
            aw_idx_q  <= '0;
            w_have_q  <= 1'b0;
            w_data_q  <= 8'h00;
            w_stb_q   <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= eeu_pkg::RESP_OKAY;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= eeu_pkg::RESP_OKAY;
        end
        else
        begin
            aw_have_q <= aw_have_d;
            aw_idx_q  <= aw_idx_d;
            w_have_q  <= w_have_d;
            w_data_q  <= w_data_d;
            w_stb_q   <= w_stb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    assign wr_ctrl   = wr_go && w_stb_q && (aw_idx_q == eeu_pkg::IDX_CTRL);
    // The permit bit must already be set before the go write; one write cannot both permit and go.
    assign go_req    = wr_ctrl && w_data_q[eeu_pkg::CTRL_GO] && (ulk_q == eeu_pkg::ULK_ARMED) &&
                       permit_q && !go_q && !ext_f_q;
    assign rd_req    = wr_ctrl && w_data_q[eeu_pkg::CTRL_RD] && !go_q && !rd_q && !ext_f_q;
    assign prog_end  = go_q && !ext_f_q && (cnt_q == CNT_LAST);
    assign cut_short = go_q && ext_f_q;

    assign mem_bus.re    = rd_req;
    assign mem_bus.addr  = rd_req ? addr_q : paddr_q;
    assign mem_bus.we    = prog_end;
    assign mem_bus.wdata = pdata_q;

    always_comb
    begin
        done_d   = done_q;
        abort_d  = abort_q;
        permit_d = permit_q;
        go_d     = go_q;
        rd_d     = rd_q;
        data_d   = data_q;
        addr_d   = addr_q;
        paddr_d  = paddr_q;
        pdata_d  = pdata_q;
        cnt_d    = cnt_q;
        stat_d   = stat_q;
        mask_d   = mask_q;
        ulk_d    = ulk_q;
        if (wr_go && w_stb_q)
        begin
            case (aw_idx_q)
                eeu_pkg::IDX_DATA: data_d = w_data_q;
                eeu_pkg::IDX_ADDR: addr_d = w_data_q;
                eeu_pkg::IDX_MASK: mask_d = w_data_q[1:0];
                eeu_pkg::IDX_CTRL:
                begin
                    permit_d = w_data_q[eeu_pkg::CTRL_PERMIT];
                    done_d   = done_q && w_data_q[eeu_pkg::CTRL_DONE];
                    abort_d  = abort_q && w_data_q[eeu_pkg::CTRL_ABORT];
                end
                default:
                begin
                end
            endcase
        end
        // Unlock tracker: a read, or any write other than 55h or the awaited AAh, falls back to idle.
        if (ar_fire)
        begin
            ulk_d = eeu_pkg::ULK_IDLE;
        end
        else if (wr_go)
        begin
            if (w_stb_q && (aw_idx_q == eeu_pkg::IDX_UNLK) && (w_data_q == eeu_pkg::KEY_FIRST))
            begin
                ulk_d = eeu_pkg::ULK_GOT1;
            end
            else if (w_stb_q && (aw_idx_q == eeu_pkg::IDX_UNLK) && (w_data_q == eeu_pkg::KEY_SECOND) &&
                     (ulk_q == eeu_pkg::ULK_GOT1))
            begin
                ulk_d = eeu_pkg::ULK_ARMED;
            end
            else
            begin
                ulk_d = eeu_pkg::ULK_IDLE;
            end
        end
        // The cycle works on its own copies, so later register writes cannot alter it.
        if (go_req)
        begin
            go_d    = 1'b1;
            cnt_d   = '0;
            paddr_d = addr_q;
            pdata_d = data_q;
        end
        else if (prog_end)
        begin
            go_d    = 1'b0;
            done_d  = 1'b1;
            abort_d = 1'b0;
        end
        else if (go_q)
        begin
            cnt_d = cnt_q + 1'b1;
        end
        if (rd_req)
        begin
            rd_d = 1'b1;
        end
        else if (rd_q)
        begin
            rd_d   = 1'b0;
            data_d = mem_bus.rdata;
        end
        if (ar_fire && (ar_idx == eeu_pkg::IDX_STAT))
        begin
            stat_d = 2'h0;
        end
        stat_d[eeu_pkg::STAT_DONE]  = stat_d[eeu_pkg::STAT_DONE] || prog_end;
        stat_d[eeu_pkg::STAT_ABORT] = stat_d[eeu_pkg::STAT_ABORT] || cut_short;
        // A system reset request ends any cycle; the cell keeps its old value.
        if (ext_f_q)
        begin
            permit_d = 1'b0;
            go_d     = 1'b0;
            rd_d     = 1'b0;
            cnt_d    = '0;
            ulk_d    = eeu_pkg::ULK_IDLE;
            abort_d  = abort_q || cut_short;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
        begin
            done_q   <= 1'b0;
            abort_q  <= 1'b0;
            permit_q <= 1'b0;
            go_q     <= 1'b0;
            rd_q     <= 1'b0;
            data_q   <= eeu_pkg::DATA_RST;
            addr_q   <= eeu_pkg::ADDR_RST;
            paddr_q  <= eeu_pkg::ADDR_RST;
            pdata_q  <= eeu_pkg::DATA_RST;
            cnt_q    <= '0;
            stat_q   <= eeu_pkg::STAT_RST;
            mask_q   <= eeu_pkg::MASK_RST;
            ulk_q    <= eeu_pkg::ULK_IDLE;
        end
        else
        begin
            done_q   <= done_d;
            abort_q  <= abort_d;
            permit_q <= permit_d;
            go_q     <= go_d;
            rd_q     <= rd_d;
            data_q   <= data_d;
            addr_q   <= addr_d;
            paddr_q  <= paddr_d;
            pdata_q  <= pdata_d;
            cnt_q    <= cnt_d;
            stat_q   <= stat_d;
            mask_q   <= mask_d;
            ulk_q    <= ulk_d;
        end
    end
endmodule

`default_nettype wire

// file: hdl/eeu_pkg.sv
// Purpose: Shared constants and types for the data EEPROM write-unlock block.
// Assumes: A 100 MHz system clock and one AXI4-Lite slave port with 32-bit data.
// Notes: Register offsets are word indices; the byte address is four times the index.
// Function
// - Write starts only after 55h, AAh, go.
// - Go bit blocked while write permit clear.
// - Hardware never clears the write permit bit; the code clears it on a system reset request.
// - Clearing permit never disturbs a running write.
// - Completion clears go and sets done flag.
// - Done flag cleared only by software.
// - Control holds done, abort, permit, go, read.
// - Read trigger loads data register next cycle.
// - Read trigger set by software, cleared by hardware.
// - Reset during a write sets abort flag; the code sets it on a system reset request only, and RST_B clears it.
`default_nettype none

package eeu_pkg;

    localparam int unsigned IDX_W = 12;
    localparam int unsigned AXI_AW = 14;

    localparam logic [11:0] IDX_DATA = 12'h008;
    localparam logic [11:0] IDX_ADDR = 12'h009;
    localparam logic [11:0] IDX_CTRL = 12'h088;
    localparam logic [11:0] IDX_UNLK = 12'h089;
    localparam logic [11:0] IDX_STAT = 12'h090;
    localparam logic [11:0] IDX_MASK = 12'h091;

    localparam int unsigned CTRL_DONE = 4;
    localparam int unsigned CTRL_ABORT = 3;
    localparam int unsigned CTRL_PERMIT = 2;
    localparam int unsigned CTRL_GO = 1;
    localparam int unsigned CTRL_RD = 0;

    localparam int unsigned STAT_DONE = 0;
    localparam int unsigned STAT_ABORT = 1;

    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] ADDR_RST = 8'h00;
    localparam logic [1:0] STAT_RST = 2'h0;
    localparam logic [1:0] MASK_RST = 2'h0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned PROG_TIME_NS = 4000;
    localparam int unsigned PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0]
    {
        ULK_IDLE  = 2'b00,
        ULK_GOT1  = 2'b01,
        ULK_ARMED = 2'b10
    } eeu_ulk_t;

endpackage

`default_nettype wire

// file: hdl/eeu_mem_if.sv
// Purpose: Carrier between the control logic and the cell array.
// Assumes: One access per cycle, write and read never together.
// Notes: Read data is registered inside the array module.
`default_nettype none

interface eeu_mem_if #(
    parameter int unsigned AW = 8,
    parameter int unsigned DW = 8
);
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    logic          we;
    logic          re;

    modport ctl (output addr, output wdata, output we, output re, input rdata);
    modport mem (input addr, input wdata, input we, input re, output rdata);
endinterface

`default_nettype wire

// file: hdl/eeu_mem.sv
// Purpose: Byte-wide cell array of the data EEPROM.
// Assumes: Same clock as the control logic.
// Notes: Cells have no reset, as they model retained contents.
`default_nettype none

module eeu_mem #(
    parameter int unsigned AW = 8,
    parameter int unsigned DW = 8
) (
    input  wire logic clk,
    input  wire logic rst_b,
    eeu_mem_if.mem    port
);
    logic [DW-1:0] cells [2**AW];
    logic [DW-1:0] rd_q;
    logic [DW-1:0] rd_d;

    always_comb
    begin
        rd_d = port.re ? cells[port.addr] : rd_q;
    end

    always_ff @(posedge clk)
    begin
        if (port.we)
        begin
            cells[port.addr] <= port.wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_q <= '0;
        end
        else
        begin
            rd_q <= rd_d;
        end
    end

    assign port.rdata = rd_q;
endmodule

`default_nettype wire

// file: testbench/eeu_chk_sva.sv
// Purpose: Port-level assertions for the EEPROM write-unlock block.
// Assumes: One clock, RST_B asynchronous and active low.
// Notes: Bound to eeu_top below the module.
`default_nettype none

module eeu_chk (
    input wire logic        CLK_SYS,
    input wire logic        RST_B,
    input wire logic        S_AXI_AWVALID,
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic [1:0]  S_AXI_BRESP,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [13:0] S_AXI_ARADDR,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    input wire logic [31:0] S_AXI_RDATA
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_B);

    sequence s_wr_both;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    sequence s_rd_take;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence

    a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped or changed");
    a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped or changed");
    a_write_refused: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write channel ready during response");
    a_read_refused: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("address ready during read response");
    a_read_answer: assert property (s_rd_take |=> S_AXI_RVALID)
        else $error("read answer late");
    a_write_answer: assert property (s_wr_both |-> ##[1:3] S_AXI_BVALID)
        else $error("write answer late");
    a_bresp_code: assert property (S_AXI_BVALID |-> S_AXI_BRESP == 2'h0 || S_AXI_BRESP == 2'h2)
        else $error("illegal write response code");
    a_ctrl_upper: assert property (s_rd_take ##0 (S_AXI_ARADDR[13:2] == eeu_pkg::IDX_CTRL) |=> S_AXI_RDATA[31:5] == 0)
        else $error("unimplemented control bits set");
endmodule

bind eeu_top eeu_chk eeu_chk_inst (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA));

`default_nettype wire

// file: testbench/tb_top.sv
// Purpose: Self-checking bench for the EEPROM write-unlock block.
// Assumes: Short programming time set through PROG_CYCLES.
// Notes: Every bus wait is bounded; a hang ends the run as a failure.
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned PC     = 20;
    localparam logic [13:0] A_DATA = {eeu_pkg::IDX_DATA, 2'b00};
    localparam logic [13:0] A_ADDR = {eeu_pkg::IDX_ADDR, 2'b00};
    localparam logic [13:0] A_CTRL = {eeu_pkg::IDX_CTRL, 2'b00};
    localparam logic [13:0] A_UNLK = {eeu_pkg::IDX_UNLK, 2'b00};
    localparam logic [13:0] A_STAT = {eeu_pkg::IDX_STAT, 2'b00};
    localparam logic [13:0] A_MASK = {eeu_pkg::IDX_MASK, 2'b00};
    localparam logic [13:0] A_BAD  = 14'h0100;
    logic        clk, rst_b, ext_rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, irq;
    logic [13:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    int          num_errors, check_count;

    eeu_top #(.PROG_CYCLES(PC)) eeu_top_inst (.CLK_SYS(clk), .RST_B(rst_b), .EXT_RST_REQ(ext_rst),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h1), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_ARADDR(araddr), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .IRQ(irq));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic give_verdict;
        if (num_errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic hang(input int n);
        if (n > 60)
        begin
            chk("handshake", 32'h0000_0001, 32'h0000_0000);
            give_verdict;
        end
    endtask

    task automatic axi_wr(input logic [13:0] a, input logic [7:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        awvalid <= 1'b1;
        awaddr  <= a;
        wvalid  <= 1'b1;
        wdata   <= {24'h00_0000, d};
        bready  <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            n++;
            hang(n);
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [13:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        arvalid <= 1'b1;
        araddr  <= a;
        rready  <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            n++;
            hang(n);
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic w(input logic [13:0] a, input logic [7:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        chk("write response", {30'h0, eeu_pkg::RESP_OKAY}, {30'h0, r});
    endtask

    task automatic rc(input string nm, input logic [13:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        chk(nm, exp, d);
        // The deliberately unmapped address must be refused; every register answers OKAY.
        chk("read response", {30'h0, ((a == A_BAD) ? eeu_pkg::RESP_SLVERR : eeu_pkg::RESP_OKAY)}, {30'h0, r});
    endtask

    task automatic irq_is(input logic exp);
        @(negedge clk);
        chk("irq", {31'h0, exp}, {31'h0, irq});
    endtask

    // Permit, both keys, then go, each as its own bus write.
    // Nothing else touches the bus between the steps, so the sequence is never split.
    task automatic do_go;
        w(A_CTRL, 8'h04);
        w(A_UNLK, 8'h55);
        w(A_UNLK, 8'hAA);
        w(A_CTRL, 8'h06);
    endtask

    task automatic wait_idle;
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        n = 0;
        do
        begin
            axi_rd(A_CTRL, d, r);
            n++;
            hang(n);
        end while (d[1] !== 1'b0);
    endtask

    task automatic t_reset;
        logic [1:0] r;
        rc("control", A_CTRL, 32'h0000_0000);
        rc("data", A_DATA, 32'h0000_0000);
        rc("address", A_ADDR, 32'h0000_0000);
        rc("unlock", A_UNLK, 32'h0000_0000);
        rc("status", A_STAT, 32'h0000_0000);
        rc("mask", A_MASK, 32'h0000_0000);
        rc("unmapped", A_BAD, 32'h0000_0000);
        axi_wr(A_BAD, 8'hFF, r);
        chk("unmapped response", {30'h0, eeu_pkg::RESP_SLVERR}, {30'h0, r});
        irq_is(1'b0);
    endtask

    task automatic t_write;
        w(A_DATA, 8'hA5);
        w(A_ADDR, 8'h3C);
        do_go;
        rc("control busy", A_CTRL, 32'h0000_0006);
        w(A_CTRL, 8'h00);
        wait_idle;
        rc("control done", A_CTRL, 32'h0000_0010);
        w(A_DATA, 8'h00);
        w(A_CTRL, 8'h11);
        rc("readback", A_DATA, 32'h0000_00A5);
        rc("control after read", A_CTRL, 32'h0000_0010);
        w(A_CTRL, 8'h00);
        rc("control cleared", A_CTRL, 32'h0000_0000);
    endtask

    task automatic t_broken;
        w(A_CTRL, 8'h04);
        w(A_UNLK, 8'h55);
        rc("data", A_DATA, 32'h0000_00A5);
        w(A_UNLK, 8'hAA);
        w(A_CTRL, 8'h06);
        rc("control split", A_CTRL, 32'h0000_0004);
        w(A_UNLK, 8'hAA);
        w(A_UNLK, 8'h55);
        w(A_CTRL, 8'h06);
        rc("control reversed", A_CTRL, 32'h0000_0004);
        w(A_CTRL, 8'h00);
        w(A_UNLK, 8'h55);
        w(A_UNLK, 8'hAA);
        w(A_CTRL, 8'h02);
        rc("control no permit", A_CTRL, 32'h0000_0000);
    endtask

    task automatic t_irq;
        w(A_MASK, 8'h01);
        w(A_ADDR, 8'h10);
        w(A_DATA, 8'h3C);
        do_go;
        wait_idle;
        irq_is(1'b1);
        rc("control done", A_CTRL, 32'h0000_0014);
        w(A_MASK, 8'h00);
        irq_is(1'b0);
        w(A_MASK, 8'h01);
        irq_is(1'b1);
        rc("status", A_STAT, 32'h0000_0001);
        irq_is(1'b0);
        rc("control kept", A_CTRL, 32'h0000_0014);
    endtask

    task automatic t_abort;
        do_go;
        ext_rst <= 1'b1;
        repeat (4) @(posedge clk);
        ext_rst <= 1'b0;
        repeat (8) @(posedge clk);
        rc("control cut", A_CTRL, 32'h0000_0008);
        rc("status cut", A_STAT, 32'h0000_0002);
        irq_is(1'b0);
        do_go;
        wait_idle;
        rc("control normal", A_CTRL, 32'h0000_0014);
    endtask

    initial
    begin
        num_errors  = 0;
        check_count = 0;
        rst_b   = 1'b0;
        ext_rst = 1'b0;
        awvalid = 1'b0;
        awaddr  = 14'h0000;
        wvalid  = 1'b0;
        wdata   = 32'h0000_0000;
        bready  = 1'b0;
        arvalid = 1'b0;
        araddr  = 14'h0000;
        rready  = 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        t_reset;
        t_write;
        t_broken;
        t_irq;
        t_abort;
        give_verdict;
    end
endmodule

`default_nettype wire
